// File: design/chrb_consts.vh
// Function
// - bit7 config picks standard or jeita profile
// - bit6 picks balance start 3.5V/3.7V
// - bits5,4 pick mismatch thresholds 50/70mV
// - 6k resistor: 500mA offset, 100mA steps
// - 24k resistor: 125mA offset, 25mA steps
// - timer bit7 picks 600/1200kHz switching
// - watchdog limit off/40/80/160s, kick restarts
// - soft reset restores defaults, self-clears
// - safety timer off/8h/20h/12h, default 20h
// - status bits5:4 report charge phase
// - status bits3:0 hold read-only regulation flags
// - fault bits7:3 hold read-only fault flags
// - fault bits2:0 hold thermistor zone code
// - watchdog expiry restores config and timer fields, keeps timer bits6:4
// - boost off when boost_run low, charge off or done, zone or overvolt fault, or safety timeout
// - target address 4bh, nack undefined register
`ifndef CHRB_CONSTS_VH
`define CHRB_CONSTS_VH
`define CHRB_DEV_ADDR        7'h4b
`define CHRB_OFS_CFG         8'h01
`define CHRB_OFS_TMR         8'h02
`define CHRB_OFS_STAT        8'h03
`define CHRB_OFS_FAULT       8'h04
`define CHRB_RST_CFG         8'h8f
`define CHRB_RST_TMR         8'h95
`define CHRB_TMR_WDT_MASK    8'h70
`define CHRB_TMR_KICK_BIT    6
`define CHRB_TMR_SRST_BIT    3
`define CHRB_CLK_HZ          200000000
`define CHRB_WD_S_01         40
`define CHRB_WD_S_10         80
`define CHRB_WD_S_11         160
`define CHRB_CFG_PROF_BIT    7
`define CHRB_CFG_BSTART_BIT  6
`define CHRB_CFG_BFALL_BIT   5
`define CHRB_CFG_BRISE_BIT   4
`define CHRB_CFG_ICC_MSB     3
`define CHRB_TMR_FSW_BIT     7
`define CHRB_TMR_WD_MSB      5
`define CHRB_TMR_WD_LSB      4
`define CHRB_TMR_SAFE_MSB    2
`define CHRB_TMR_SAFE_LSB    1
`define CHRB_TMR_RUN_BIT     0
`define CHRB_ZONE_OK         3'h0
`define CHRB_SAFE_UNIT_S     3600
`define CHRB_MA_OFS_6K       12'd500
`define CHRB_MA_STEP_6K      12'd100
`define CHRB_MA_OFS_24K      12'd125
`define CHRB_MA_STEP_24K     12'd25
`define CHRB_SAFE_H_01       8'd8
`define CHRB_SAFE_H_10       8'd20
`define CHRB_SAFE_H_11       8'd12
`endif

// File: design/chrb_regs.v
`timescale 1ns/1ps
`include "chrb_consts.vh"
module chrb_regs #(
  parameter SEC_CYC = `CHRB_CLK_HZ
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_oe_n,
  input  wire        iset_24k,
  input  wire [1:0]  charge_phase,
  input  wire        input_limit_flag,
  input  wire        battery_absent_flag,
  input  wire        thermal_reg_flag,
  input  wire        sys_floor_flag,
  input  wire        input_ovp,
  input  wire        overheat_shutdown_flag,
  input  wire        battery_overvolt_flag,
  input  wire [2:0]  thermistor_zone_code,
  input  wire        charge_enabled,
  input  wire        charge_done,
  output reg         thermistor_profile_sel,
  output reg         balance_start_sel,
  output reg         balance_fall_thresh,
  output reg         balance_rise_thresh,
  output reg  [11:0] fast_chg_ma,
  output reg         switch_freq_sel,
  output reg         boost_on,
  output reg         safety_expired,
  output reg         wdog_expired_flag
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_ADDR = 6'b000010;
  localparam ST_REG  = 6'b000100;
  localparam ST_DATA = 6'b001000;
  localparam ST_RD   = 6'b010000;
  localparam ST_ACK  = 6'b100000;

  // pins pass two flops
  wire scl_s;
  wire sda_s;
  chrb_sync #(.W(1)) u_scl (.clk_sys(clk_sys), .rst_n(rst_n), .d(scl_in), .q(scl_s));
  chrb_sync #(.W(1)) u_sda (.clk_sys(clk_sys), .rst_n(rst_n), .d(sda_in), .q(sda_s));

  reg        scl_d;
  reg        sda_d;
  reg [5:0]  state;
  reg [5:0]  after_ack;
  reg [3:0]  bitn;
  reg [7:0]  shreg;
  reg [7:0]  reg_ptr;
  reg        do_ack;
  reg [7:0]  cfg;
  reg [7:0]  tmr;
  reg [7:0]  next_cfg;
  reg [7:0]  next_tmr;
  reg [7:0]  rd_byte;
  reg        wr_stb;
  reg        kick;
  wire       wdog_hit;
  wire       safe_hit;
  reg        wdog_hit_q;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire shr_ok   = shreg >= `CHRB_OFS_CFG && shreg <= `CHRB_OFS_FAULT;

  wire [7:0] stat_rd  = {2'b00, charge_phase, input_limit_flag, battery_absent_flag,
                         thermal_reg_flag, sys_floor_flag};
  wire [7:0] fault_rd = {wdog_expired_flag, input_ovp, overheat_shutdown_flag,
                         safety_expired, battery_overvolt_flag, thermistor_zone_code};

  always @* begin
    case (reg_ptr)
      `CHRB_OFS_CFG:   rd_byte = cfg;
      `CHRB_OFS_TMR:   rd_byte = tmr;
      `CHRB_OFS_STAT:  rd_byte = stat_rd;
      `CHRB_OFS_FAULT: rd_byte = fault_rd;
      default:         rd_byte = 8'h00;
    endcase
  end

  // serial target: single byte write, or address then read
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bitn <= 4'h0;
      shreg <= 8'h00;
      reg_ptr <= 8'h00;
      do_ack <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_stb <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      wr_stb <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        bitn <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: sda_oe_n <= 1'b1;
          ST_ADDR, ST_REG, ST_DATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitn <= bitn + 4'h1;
            end
            if (scl_fall && bitn == 4'h8) begin
              bitn <= 4'h0;
              state <= ST_ACK;
              if (state == ST_ADDR) begin
                do_ack <= shreg[7:1] == `CHRB_DEV_ADDR;
                after_ack <= shreg[0] ? ST_RD : ST_REG;
                sda_oe_n <= ~(shreg[7:1] == `CHRB_DEV_ADDR);
              end else if (state == ST_REG) begin
                reg_ptr <= shreg;
                do_ack <= shr_ok;
                after_ack <= ST_DATA;
                sda_oe_n <= ~shr_ok;
              end else begin
                do_ack <= 1'b1;
                after_ack <= ST_IDLE;
                wr_stb <= 1'b1;
                sda_oe_n <= 1'b0;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!do_ack) begin
                state <= ST_IDLE;
                sda_oe_n <= 1'b1;
              end else if (after_ack == ST_RD) begin
                state <= ST_RD;
                shreg <= rd_byte;
                sda_oe_n <= rd_byte[7];
                bitn <= 4'h1;
              end else begin
                state <= after_ack;
                sda_oe_n <= 1'b1;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bitn == 4'h8) begin
                state <= ST_IDLE;
                sda_oe_n <= 1'b1;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe_n <= shreg[6];
                bitn <= bitn + 4'h1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // register update, soft reset and watchdog restore
  always @* begin
    next_cfg = cfg;
    next_tmr = tmr;
    kick = 1'b0;
    if (wr_stb && reg_ptr == `CHRB_OFS_CFG)
      next_cfg = shreg;
    if (wr_stb && reg_ptr == `CHRB_OFS_TMR) begin
      next_tmr = shreg;
      kick = shreg[`CHRB_TMR_KICK_BIT];
    end
    if (tmr[`CHRB_TMR_SRST_BIT]) begin
      next_cfg = `CHRB_RST_CFG;
      next_tmr = `CHRB_RST_TMR;
    end else if (wdog_hit) begin
      next_cfg = `CHRB_RST_CFG;
      next_tmr = (tmr & `CHRB_TMR_WDT_MASK) | (`CHRB_RST_TMR & ~`CHRB_TMR_WDT_MASK);
      next_tmr[`CHRB_TMR_SRST_BIT] = tmr[`CHRB_TMR_SRST_BIT];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg <= `CHRB_RST_CFG;
      tmr <= `CHRB_RST_TMR;
    end else begin
      cfg <= next_cfg;
      tmr <= next_tmr;
    end
  end

  // watchdog: 40s times 1,2,4
  reg  [31:0] wd_lim;
  reg  [31:0] safe_lim;
  always @* begin
    case (tmr[`CHRB_TMR_WD_MSB:`CHRB_TMR_WD_LSB])
      2'b01:   wd_lim = `CHRB_WD_S_01;
      2'b10:   wd_lim = `CHRB_WD_S_10;
      2'b11:   wd_lim = `CHRB_WD_S_11;
      default: wd_lim = 32'h0000_0000;
    endcase
    case (tmr[`CHRB_TMR_SAFE_MSB:`CHRB_TMR_SAFE_LSB])
      2'b01:   safe_lim = `CHRB_SAFE_H_01 * `CHRB_SAFE_UNIT_S;
      2'b10:   safe_lim = `CHRB_SAFE_H_10 * `CHRB_SAFE_UNIT_S;
      2'b11:   safe_lim = `CHRB_SAFE_H_11 * `CHRB_SAFE_UNIT_S;
      default: safe_lim = 32'h0000_0000;
    endcase
  end
  chrb_tick #(.SEC_CYC(SEC_CYC)) u_wd (
    .clk_sys(clk_sys), .rst_n(rst_n), .clr(kick | wr_stb | wdog_hit_q),
    .limit_s(wd_lim), .expired(wdog_hit));
  chrb_tick #(.SEC_CYC(SEC_CYC)) u_safe (
    .clk_sys(clk_sys), .rst_n(rst_n), .clr(~charge_enabled | charge_done),
    .limit_s(safe_lim), .expired(safe_hit));

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wdog_hit_q <= 1'b0;
      wdog_expired_flag <= 1'b0;
      safety_expired <= 1'b0;
      thermistor_profile_sel <= 1'b1;
      balance_start_sel <= 1'b0;
      balance_fall_thresh <= 1'b0;
      balance_rise_thresh <= 1'b0;
      fast_chg_ma <= 12'd0;
      switch_freq_sel <= 1'b1;
      boost_on <= 1'b0;
    end else begin
      wdog_hit_q <= wdog_hit;
      if (wdog_hit)
        wdog_expired_flag <= 1'b1;
      else if (kick)
        wdog_expired_flag <= 1'b0;
      safety_expired <= safe_hit;
      thermistor_profile_sel <= cfg[`CHRB_CFG_PROF_BIT];
      balance_start_sel <= cfg[`CHRB_CFG_BSTART_BIT];
      balance_fall_thresh <= cfg[`CHRB_CFG_BFALL_BIT];
      balance_rise_thresh <= cfg[`CHRB_CFG_BRISE_BIT];
      if (iset_24k)
        fast_chg_ma <= `CHRB_MA_OFS_24K + `CHRB_MA_STEP_24K * {8'h00, cfg[`CHRB_CFG_ICC_MSB:0]};
      else
        fast_chg_ma <= `CHRB_MA_OFS_6K + `CHRB_MA_STEP_6K * {8'h00, cfg[`CHRB_CFG_ICC_MSB:0]};
      switch_freq_sel <= tmr[`CHRB_TMR_FSW_BIT];
      boost_on <= tmr[`CHRB_TMR_RUN_BIT] & charge_enabled & ~charge_done
                  & (thermistor_zone_code == `CHRB_ZONE_OK)
                  & ~safe_hit & ~battery_overvolt_flag;
    end
  end
endmodule

// File: design/chrb_sync.v
`timescale 1ns/1ps
module chrb_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      // bus pins idle high, so no false edge after reset
      meta <= {W{1'b1}};
      q    <= {W{1'b1}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: design/chrb_tick.v
`timescale 1ns/1ps
// counts clock cycles into one-second ticks, then seconds up to a limit
module chrb_tick #(
  parameter SEC_CYC = 200000000
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        clr,
  input  wire [31:0] limit_s,
  output reg         expired
);
  reg [31:0] cyc;
  reg [31:0] secs;
  always @(posedge clk_sys) begin
    if (!rst_n || clr || limit_s == 32'h0000_0000) begin
      cyc     <= 32'h0000_0000;
      secs    <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (!expired) begin
      if (cyc == SEC_CYC - 1) begin
        cyc  <= 32'h0000_0000;
        secs <= secs + 32'h0000_0001;
        if (secs + 32'h0000_0001 >= limit_s)
          expired <= 1'b1;
      end else begin
        cyc <= cyc + 32'h0000_0001;
      end
    end
  end
endmodule

// File: verification/charger_host_register_bank_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks = checks + 1; if ((g) !== (e)) begin miscompares = miscompares + 1; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module charger_host_register_bank_tb;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg         iset_24k = 1'b0;
  reg  [1:0]  charge_phase = 2'h0;
  reg  [3:0]  sflag = 4'h0;
  reg         input_ovp = 1'b0;
  reg         ovh = 1'b0;
  reg         bov = 1'b0;
  reg  [2:0]  zone = 3'h0;
  reg         chg_en = 1'b0;
  reg         chg_done = 1'b0;
  wire        scl, sda_low, sda_oe_n, prof, bstart, bfall, brise, freq, boost, safe, wdf;
  wire [11:0] ma;
  wire        sda_line = !(sda_low | !sda_oe_n);
  integer     seed = 56286;
  integer     checks = 0;
  integer     miscompares = 0;
  integer     n;
  reg  [31:0] r;
  reg  [7:0]  d, q;
  reg  [2:0]  ak;
  always #2.5 clk_sys = ~clk_sys;
  chrb_regs #(.SEC_CYC(200)) i_chrb_regs (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_oe_n(sda_oe_n), .iset_24k(iset_24k), .charge_phase(charge_phase), .input_limit_flag(sflag[3]),
    .battery_absent_flag(sflag[2]), .thermal_reg_flag(sflag[1]), .sys_floor_flag(sflag[0]),
    .input_ovp(input_ovp), .overheat_shutdown_flag(ovh), .battery_overvolt_flag(bov),
    .thermistor_zone_code(zone), .charge_enabled(chg_en), .charge_done(chg_done),
    .thermistor_profile_sel(prof), .balance_start_sel(bstart), .balance_fall_thresh(bfall),
    .balance_rise_thresh(brise), .fast_chg_ma(ma), .switch_freq_sel(freq), .boost_on(boost),
    .safety_expired(safe), .wdog_expired_flag(wdf));
  chrb_host i_chrb_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  function [11:0] ma_exp(input i24, input [3:0] k);
    ma_exp = i24 ? 12'd125 + 12'd25 * k : 12'd500 + 12'd100 * k;
  endfunction
  function boost_exp(input run);
    boost_exp = run & chg_en & !chg_done & ~|zone & !bov;
  endfunction
  task rd_chk(input [7:0] ra, input [7:0] e);
    begin
      i_chrb_host.access(1'b1, ra, 8'h00, q, ak);
      `CHK("rd_ack", 3'b111, ak)
      `CHK("rdata", e, q)
    end
  endtask
  task wr(input [7:0] ra, input [7:0] wd);
    begin
      i_chrb_host.access(1'b0, ra, wd, q, ak);
      `CHK("wr_ack", 3'b111, ak)
    end
  endtask
  task rnd_in;
    begin
      @(posedge clk_sys);
      r = $random(seed);
      iset_24k <= r[0];
      charge_phase <= r[2:1];
      sflag <= r[6:3];
      input_ovp <= r[7];
      ovh <= r[8];
      bov <= r[9];
      chg_en <= r[10];
      chg_done <= r[11];
      zone <= 3'b001 << r[13:12];
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk(8'h01, 8'h8f);
    rd_chk(8'h02, 8'h95);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h00);
    `CHK("ma", 12'd2000, ma)
    $display("test defaults done");
    wr(8'h02, 8'h85);
    for (n = 0; n < 6; n = n + 1) begin
      rnd_in;
      d = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : $random(seed);
      wr(8'h01, d);
      rd_chk(8'h01, d);
      `CHK("cfg", {d[7:4], ma_exp(iset_24k, d[3:0])}, {prof, bstart, bfall, brise, ma})
      rd_chk(8'h03, {2'b00, charge_phase, sflag});
      rd_chk(8'h04, {1'b0, input_ovp, ovh, 1'b0, bov, zone});
      `CHK("boost", boost_exp(1'b1), boost)
      `CHK("safe", 1'b0, safe)
    end
    $display("test random config done");
    wr(8'h03, 8'hff);
    rd_chk(8'h03, {2'b00, charge_phase, sflag});
    i_chrb_host.access(1'b0, 8'h00, 8'h12, q, ak);
    `CHK("nack", 3'b100, ak)
    i_chrb_host.access(1'b0, 8'h05, 8'h12, q, ak);
    `CHK("nack", 3'b100, ak)
    wr(8'h02, 8'h84);
    `CHK("boost_off", 1'b0, boost)
    wr(8'h01, 8'h55);
    wr(8'h02, 8'h08);
    rd_chk(8'h01, 8'h8f);
    rd_chk(8'h02, 8'h95);
    $display("test refuse and soft reset done");
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h10);
    `CHK("wdf_idle", 1'b0, wdf)
    repeat (8400) @(posedge clk_sys);
    `CHK("wdf", 1'b1, wdf)
    `CHK("wd_out", 2'b11, {prof, freq})
    rd_chk(8'h02, 8'h95);
    rd_chk(8'h01, 8'h8f);
    rd_chk(8'h04, {1'b1, input_ovp, ovh, 1'b0, bov, zone});
    wr(8'h02, 8'h55);
    `CHK("wdf_kick", 1'b0, wdf)
    $display("test watchdog done");
    wrap_up;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule

// File: verification/chrb_host.sv
`timescale 1ns/1ps
module chrb_host (
  input  wire clk_sys,
  input  wire sda_line,
  output reg  scl,
  output reg  sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task hold;
    repeat (8) @(posedge clk_sys);
  endtask
  task bitx(input b, output r);
    begin
      sda_low <= !b;
      hold;
      scl <= 1'b1;
      hold;
      r = sda_line;
      scl <= 1'b0;
      hold;
    end
  endtask
  task start;
    begin
      sda_low <= 1'b0;
      hold;
      scl <= 1'b1;
      hold;
      sda_low <= 1'b1;
      hold;
      scl <= 1'b0;
      hold;
    end
  endtask
  task xfer(input [7:0] d, output [7:0] q, output ack);
    integer i;
    reg     a;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitx(d[i], q[i]);
      bitx(1'b1, a);
      ack = !a;
    end
  endtask
  // single byte access; read ends with host nack then stop
  task access(input rd, input [7:0] ra, input [7:0] wd, output [7:0] q, output [2:0] ak);
    reg [7:0] dump;
    begin
      start;
      xfer({7'h4b, 1'b0}, dump, ak[2]);
      xfer(ra, dump, ak[1]);
      if (rd) begin
        start;
        xfer({7'h4b, 1'b1}, dump, ak[0]);
        xfer(8'hff, q, dump[0]);
      end else
        xfer(wd, dump, ak[0]);
      sda_low <= 1'b1;
      hold;
      scl <= 1'b1;
      hold;
      sda_low <= 1'b0;
      hold;
    end
  endtask
endmodule

// File: verification/chrb_regs_asserts.sv
`timescale 1ns/1ps
module chrb_regs_asserts (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        scl_in,
  input wire        sda_oe_n,
  input wire        iset_24k,
  input wire        charge_enabled,
  input wire        charge_done,
  input wire        battery_overvolt_flag,
  input wire [2:0]  thermistor_zone_code,
  input wire        thermistor_profile_sel,
  input wire        balance_start_sel,
  input wire        switch_freq_sel,
  input wire [11:0] fast_chg_ma,
  input wire        boost_on,
  input wire        safety_expired,
  input wire        wdog_expired_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire stop_cond = battery_overvolt_flag | (|thermistor_zone_code) | charge_done | !charge_enabled | safety_expired;
  a_reset_vals: assert property (disable iff (1'b0) !rst_n |=> thermistor_profile_sel && switch_freq_sel
    && !balance_start_sel && !boost_on && sda_oe_n) else $error("reset values wrong");
  a_ma_6k_range: assert property (!iset_24k && $past(!iset_24k) && $past(rst_n) |->
    fast_chg_ma >= 12'd500 && fast_chg_ma <= 12'd2000 && fast_chg_ma % 100 == 0) else $error("6k current off grid");
  a_ma_24k_range: assert property (iset_24k && $past(iset_24k) && $past(rst_n) |->
    fast_chg_ma >= 12'd125 && fast_chg_ma <= 12'd500 && fast_chg_ma % 25 == 0) else $error("24k current off grid");
  a_ma_after_reset: assert property ($rose(rst_n) |-> ##1 fast_chg_ma == (iset_24k ? 12'd500 : 12'd2000))
    else $error("default current wrong");
  a_iset_rescale: assert property ($past(rst_n) && $changed(iset_24k) |=> $changed(fast_chg_ma))
    else $error("current not rescaled");
  a_boost_stop: assert property (stop_cond [*3] |-> !boost_on)
    else $error("boost runs during stop condition");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda changed while scl high");
  a_wdog_restore: assert property ($rose(wdog_expired_flag) |-> ##[0:2] (thermistor_profile_sel
    && switch_freq_sel && !balance_start_sel)) else $error("watchdog restore missing");
endmodule
bind chrb_regs chrb_regs_asserts i_chrb_regs_asserts (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .iset_24k(iset_24k), .charge_enabled(charge_enabled), .charge_done(charge_done),
  .battery_overvolt_flag(battery_overvolt_flag), .thermistor_zone_code(thermistor_zone_code),
  .thermistor_profile_sel(thermistor_profile_sel), .balance_start_sel(balance_start_sel),
  .switch_freq_sel(switch_freq_sel), .fast_chg_ma(fast_chg_ma), .boost_on(boost_on),
  .safety_expired(safety_expired), .wdog_expired_flag(wdog_expired_flag));
